// >>> logic/leism_top.v
// Link error summary, sync request masking and interrupt logic.
//
// Behaviour
// - Unexpected control summary flag at bit five
// - Per-lane unexpected control errors readable separately
// - Lane alignment failure summary flag at bit three
// - Checksum error summary flag at bit two
// - Frame alignment failure summary at bit one
// - Code group failure summary at bit zero
// - Disparity enable requests sync at threshold
// - Not-in-table enable requests sync at threshold
// - Unexpected control enable requests sync at threshold
// - Mismatch rising edge latches, interrupt goes low
// - Writing one clears the mismatch latch
// - Mismatch enable low keeps latch inactive
// - Mismatch enable bit gates mismatch interrupts
// - Per-lane error counts compared with threshold
// - Masked threshold crossing pulls interrupt low
`timescale 1ns/100ps
`include "leism_defs.vh"

module leism_top (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [13:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [13:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Per-lane error events, one-cycle pulses
    input  wire [7:0]  lane_disparity_err,
    input  wire [7:0]  lane_not_in_table_err,
    input  wire [7:0]  lane_unexpected_ctrl_err,
    // Per-lane failure levels and the configuration mismatch level
    input  wire [7:0]  lane_code_group_fail,
    input  wire [7:0]  lane_frame_align_fail,
    input  wire [7:0]  lane_checksum_err,
    input  wire [7:0]  lane_alignment_fail,
    input  wire        config_mismatch,
    // Link and interrupt outputs
    output reg         link_sync_output_n,
    output reg         irq_n
);

    // ======================================================================
    // Declarations
    // ======================================================================
    reg  [13:0] aw_addr_q;
    reg         aw_held_q;
    reg  [31:0] w_data_q;
    reg         w_strb0_q;
    reg         w_held_q;
    reg  [7:0]  irq_mask_q;
    reg  [7:0]  threshold_q;
    reg  [7:0]  lane_enable_q;
    reg         disp_sync_en_q;
    reg         nit_sync_en_q;
    reg         ucc_sync_en_q;
    reg         cmm_irq_en_q;
    reg  [7:0]  flags_prev_q;
    reg         mismatch_prev_q;
    reg  [2:0]  cnt_clear_q;
    reg  [31:0] rd_value;
    reg  [7:0]  status_clr;
    wire [11:0] wr_idx;
    wire [11:0] rd_idx;
    wire        wr_go;
    wire        wr_lane0;
    wire [7:0]  wr_byte;
    wire [7:0]  disp_reached;
    wire [7:0]  nit_reached;
    wire [7:0]  ucc_reached;
    wire [7:0]  err_flags;
    wire [7:0]  status_set;
    wire [7:0]  irq_status;
    wire [7:0]  irq_gate;
    wire        mismatch_rise;
    wire        sync_req;

    // ======================================================================
    // Address decode
    // ======================================================================
    function mapped;
        input [11:0] idx;
        begin
            case (idx)
                `LEISM_IDX_DISP_LANES,  `LEISM_IDX_NIT_LANES,
                `LEISM_IDX_UCC_LANES,   `LEISM_IDX_CGS_LANES,
                `LEISM_IDX_FRAME_LANES, `LEISM_IDX_CSUM_LANES,
                `LEISM_IDX_ILAS_LANES,  `LEISM_IDX_ERR_FLAGS,
                `LEISM_IDX_SYNC_MASK,   `LEISM_IDX_THRESHOLD,
                `LEISM_IDX_LANE_ENABLE, `LEISM_IDX_IRQ_STATUS,
                `LEISM_IDX_CNT_CLEAR,   `LEISM_IDX_IRQ_MASK: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    assign wr_idx   = aw_addr_q[13:2];
    assign rd_idx   = s_axi_araddr[13:2];
    assign wr_go    = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_lane0 = wr_go && w_strb0_q;
    assign wr_byte  = w_data_q[7:0];

    // ======================================================================
    // Write channels
    // ======================================================================
    // Address and data are held separately, so either may come first.
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q    <= 14'h0000;
            aw_held_q    <= 1'b0;
            w_data_q     <= 32'h00000000;
            w_strb0_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LEISM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
                aw_held_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q  <= s_axi_wdata;
                w_strb0_q <= s_axi_wstrb[0];
                w_held_q  <= 1'b1;
            end
            if (wr_go) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wr_idx) ? `LEISM_RESP_OKAY
                                               : `LEISM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Writable registers
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q     <= 8'h00;
            threshold_q    <= `LEISM_THRESH_RESET;
            lane_enable_q  <= `LEISM_LANE_EN_RESET;
            disp_sync_en_q <= 1'b0;
            nit_sync_en_q  <= 1'b0;
            ucc_sync_en_q  <= 1'b0;
            cmm_irq_en_q   <= 1'b0;
            cnt_clear_q    <= 3'h0;
        end else begin
            cnt_clear_q <= 3'h0;
            if (wr_lane0) begin
                case (wr_idx)
                    `LEISM_IDX_ERR_FLAGS, `LEISM_IDX_IRQ_MASK: begin
                        // The mismatch position is gated by its own enable.
                        irq_mask_q <= wr_byte & 8'hEF;
                    end
                    `LEISM_IDX_SYNC_MASK: begin
                        disp_sync_en_q <= wr_byte[`LEISM_BIT_DISP];
                        nit_sync_en_q  <= wr_byte[`LEISM_BIT_NIT];
                        ucc_sync_en_q  <= wr_byte[`LEISM_BIT_UCC];
                        cmm_irq_en_q   <= wr_byte[`LEISM_BIT_CMM_EN];
                    end
                    `LEISM_IDX_THRESHOLD: begin
                        threshold_q <= wr_byte;
                    end
                    `LEISM_IDX_LANE_ENABLE: begin
                        lane_enable_q <= wr_byte;
                    end
                    `LEISM_IDX_CNT_CLEAR: begin
                        cnt_clear_q <= wr_byte[2:0];
                    end
                    default: begin
                        cnt_clear_q <= 3'h0;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Error counting and summary flags
    // ======================================================================
    leism_err_count u_disp_count (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .err_evt   (lane_disparity_err & lane_enable_q),
        .clear     (cnt_clear_q[0]),
        .threshold (threshold_q),
        .reached   (disp_reached)
    );

    leism_err_count u_nit_count (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .err_evt   (lane_not_in_table_err & lane_enable_q),
        .clear     (cnt_clear_q[1]),
        .threshold (threshold_q),
        .reached   (nit_reached)
    );

    leism_err_count u_ucc_count (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .err_evt   (lane_unexpected_ctrl_err & lane_enable_q),
        .clear     (cnt_clear_q[2]),
        .threshold (threshold_q),
        .reached   (ucc_reached)
    );

    // Disabled lanes are left out so an idle lane cannot raise a summary.
    assign err_flags[`LEISM_BIT_DISP]  = |(disp_reached & lane_enable_q);
    assign err_flags[`LEISM_BIT_NIT]   = |(nit_reached & lane_enable_q);
    assign err_flags[`LEISM_BIT_UCC]   =
        |(ucc_reached & lane_enable_q);
    assign err_flags[`LEISM_BIT_CMM]   = 1'b0;
    assign err_flags[`LEISM_BIT_ILAS]  =
        |(lane_alignment_fail & lane_enable_q);
    assign err_flags[`LEISM_BIT_CSUM]  =
        |(lane_checksum_err & lane_enable_q);
    assign err_flags[`LEISM_BIT_FRAME] =
        |(lane_frame_align_fail & lane_enable_q);
    assign err_flags[`LEISM_BIT_CGS]   =
        |(lane_code_group_fail & lane_enable_q);

    // ======================================================================
    // Interrupt status
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            flags_prev_q    <= 8'h00;
            mismatch_prev_q <= 1'b0;
        end else begin
            flags_prev_q    <= err_flags;
            mismatch_prev_q <= config_mismatch;
        end
    end

    assign mismatch_rise = config_mismatch && !mismatch_prev_q;

    assign status_set = {err_flags[7:5] & ~flags_prev_q[7:5],
                         mismatch_rise && cmm_irq_en_q,
                         err_flags[3:0] & ~flags_prev_q[3:0]};

    always @* begin
        status_clr = 8'h00;
        if (wr_lane0 && wr_idx == `LEISM_IDX_IRQ_STATUS) begin
            status_clr = wr_byte;
        end
        if (wr_lane0 && wr_idx == `LEISM_IDX_SYNC_MASK) begin
            status_clr[`LEISM_BIT_CMM] = wr_byte[`LEISM_BIT_CMM];
        end
        if (!cmm_irq_en_q) begin
            status_clr[`LEISM_BIT_CMM] = 1'b1;
        end
    end

    leism_sticky u_status (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (status_set),
        .clr     (status_clr),
        .q       (irq_status)
    );

    assign irq_gate = {irq_mask_q[7:5], cmm_irq_en_q, irq_mask_q[3:0]};

    // ======================================================================
    // Sync request and interrupt outputs
    // ======================================================================
    assign sync_req = (disp_sync_en_q && err_flags[`LEISM_BIT_DISP])
                   || (nit_sync_en_q && err_flags[`LEISM_BIT_NIT])
                   || (ucc_sync_en_q && err_flags[`LEISM_BIT_UCC]);

    always @(posedge aclk) begin
        if (!aresetn) begin
            link_sync_output_n <= 1'b1;
            irq_n              <= 1'b1;
        end else begin
            link_sync_output_n <= !sync_req;
            irq_n              <= !(|(irq_status & irq_gate));
        end
    end

    // ======================================================================
    // Read channel
    // ======================================================================
    always @* begin
        rd_value = 32'h00000000;
        case (rd_idx)
            `LEISM_IDX_DISP_LANES:  rd_value[7:0] = disp_reached;
            `LEISM_IDX_NIT_LANES:   rd_value[7:0] = nit_reached;
            `LEISM_IDX_UCC_LANES:   rd_value[7:0] = ucc_reached;
            `LEISM_IDX_CGS_LANES:   rd_value[7:0] = lane_code_group_fail;
            `LEISM_IDX_FRAME_LANES: rd_value[7:0] = lane_frame_align_fail;
            `LEISM_IDX_CSUM_LANES:  rd_value[7:0] = lane_checksum_err;
            `LEISM_IDX_ILAS_LANES:  rd_value[7:0] = lane_alignment_fail;
            `LEISM_IDX_ERR_FLAGS:   rd_value[7:0] = err_flags;
            `LEISM_IDX_SYNC_MASK: begin
                rd_value[7:0] = {disp_sync_en_q, nit_sync_en_q,
                                 ucc_sync_en_q,
                                 irq_status[`LEISM_BIT_CMM],
                                 cmm_irq_en_q, 3'h0};
            end
            `LEISM_IDX_THRESHOLD:   rd_value[7:0] = threshold_q;
            `LEISM_IDX_LANE_ENABLE: rd_value[7:0] = lane_enable_q;
            `LEISM_IDX_IRQ_STATUS:  rd_value[7:0] = irq_status;
            `LEISM_IDX_IRQ_MASK:    rd_value[7:0] = irq_mask_q;
            default:                rd_value = 32'h00000000;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `LEISM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= mapped(rd_idx) ? `LEISM_RESP_OKAY
                                           : `LEISM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// >>> logic/leism_defs.vh
// Register indices, field positions and reset values of the link error block.
`ifndef LEISM_DEFS_VH
`define LEISM_DEFS_VH

// ====================
// Register indices (byte address is four times the index)
// ==========================================================================
`define LEISM_IDX_DISP_LANES     12'h46D
`define LEISM_IDX_NIT_LANES      12'h46E
`define LEISM_IDX_UCC_LANES      12'h46F
`define LEISM_IDX_CGS_LANES      12'h470
`define LEISM_IDX_FRAME_LANES    12'h471
`define LEISM_IDX_CSUM_LANES     12'h472
`define LEISM_IDX_ILAS_LANES     12'h473
`define LEISM_IDX_ERR_FLAGS      12'h47A
`define LEISM_IDX_SYNC_MASK      12'h47B
`define LEISM_IDX_THRESHOLD      12'h47C
`define LEISM_IDX_LANE_ENABLE    12'h47D
`define LEISM_IDX_IRQ_STATUS     12'h480
`define LEISM_IDX_CNT_CLEAR      12'h481
`define LEISM_IDX_IRQ_MASK       12'h482

// ====================
// Field positions shared by flags, status and mask
// ==========================================================================
`define LEISM_BIT_DISP           7
`define LEISM_BIT_NIT            6
`define LEISM_BIT_UCC            5
`define LEISM_BIT_CMM            4
`define LEISM_BIT_ILAS           3
`define LEISM_BIT_CSUM           2
`define LEISM_BIT_FRAME          1
`define LEISM_BIT_CGS            0
`define LEISM_BIT_CMM_EN         3

// ====================
// Reset values and widths
// ==========================================================================
`define LEISM_THRESH_RESET       8'hFF
`define LEISM_LANE_EN_RESET      8'h0F
`define LEISM_LANES              8
`define LEISM_ADDR_W             14
`define LEISM_CNT_MAX            8'hFF
`define LEISM_RESP_OKAY          2'h0
`define LEISM_RESP_SLVERR        2'h2

`endif

// >>> logic/leism_err_count.v
// Per-lane saturating error counters compared against the error threshold.
`timescale 1ns/100ps
`include "leism_defs.vh"

module leism_err_count (
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Error events and control
    input  wire [7:0] err_evt,
    input  wire       clear,
    input  wire [7:0] threshold,
    // Per-lane threshold reached
    output wire [7:0] reached
);

    genvar i;

    // ====================
    // Counters
    // ======================================================================
    generate
        for (i = 0; i < `LEISM_LANES; i = i + 1) begin : g_lane
            reg [7:0] cnt_q;
            // Saturation keeps a long burst from wrapping below threshold.
            always @(posedge aclk) begin
                if (!aresetn || clear) begin
                    cnt_q <= 8'h00;
                end else if (err_evt[i] && cnt_q != `LEISM_CNT_MAX) begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
            assign reached[i] = (cnt_q >= threshold);
        end
    endgenerate

endmodule

// >>> logic/leism_sticky.v
// Sticky status bits, set by hardware events and cleared by writing a one.
`timescale 1ns/100ps

module leism_sticky (
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Events and clears
    input  wire [7:0] set,
    input  wire [7:0] clr,
    // Held bits
    output reg  [7:0] q
);

    // ====================
    // Storage
    // ======================================================================
    // A set in the clearing cycle wins, so no event is lost.
    always @(posedge aclk) begin
        if (!aresetn) begin
            q <= 8'h00;
        end else begin
            q <= (q & ~clr) | set;
        end
    end

endmodule

// >>> test/leism_sync_rx.sv
// Far-side model that counts sync requests seen on the link sync output.
`timescale 1ns/100ps

module leism_sync_rx (
    // Clock and reset
    input  wire aclk,
    input  wire aresetn,
    // Link side
    input  wire link_sync_output_n,
    output int  req_count
);
    logic last_q;

    // A request is counted once, on the cycle the line first goes low.
    always @(posedge aclk) begin
        if (!aresetn) begin
            last_q <= 1'b1;
            req_count <= 0;
        end else begin
            last_q <= link_sync_output_n;
            if (last_q && !link_sync_output_n)
                req_count <= req_count + 1;
        end
    end
endmodule

// >>> test/leism_checker_properties.sv
// Checker of bus handshakes, answer timing and the mismatch interrupt.
`timescale 1ns/100ps

module leism_checker (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Register bus
    input wire [13:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [13:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Link side
    input wire        config_mismatch,
    input wire        link_sync_output_n,
    input wire        irq_n
);
    // ====================
    // Shadow state
    reg [11:0] aw_idx_q;
    reg [7:0]  w_data_q;
    reg        ar_bad_q;
    reg        cmm_en_q;

    function automatic bit unmapped(input [11:0] i);
        unmapped = !((i >= 12'h46D && i <= 12'h473) ||
                     (i >= 12'h47A && i <= 12'h47D) ||
                     (i >= 12'h480 && i <= 12'h482));
    endfunction

    // The enable shadow ignores the byte strobe; the bench always sets it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ar_bad_q <= 1'b0;
            cmm_en_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx_q <= s_axi_awaddr[13:2];
            end
            if (s_axi_wvalid && s_axi_wready)
                w_data_q <= s_axi_wdata[7:0];
            if (s_axi_arvalid && s_axi_arready)
                ar_bad_q <= unmapped(s_axi_araddr[13:2]);
            if (s_axi_bvalid && s_axi_bready && aw_idx_q == 12'h47B)
                cmm_en_q <= w_data_q[3];
        end
    end

    // ====================
    // Properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence cmm_rise;
        cmm_en_q && !config_mismatch ##1 config_mismatch;
    endsequence

    chk_reset_idle: assert property (disable iff (1'b0)
        !aresetn |=> irq_n && link_sync_output_n && !s_axi_bvalid)
        else $error("outputs not idle after reset");
    chk_ar_ready: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not freed");
    chk_aw_busy: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_b_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_r_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_resp_map: assert property (s_axi_bvalid |->
        s_axi_bresp == (unmapped(aw_idx_q) ? 2'h2 : 2'h0))
        else $error("write response code wrong");
    chk_rresp_map: assert property (s_axi_rvalid |->
        s_axi_rresp == (ar_bad_q ? 2'h2 : 2'h0) && s_axi_rdata[31:8] == 0)
        else $error("read response wrong");
    chk_cmm_irq: assert property (cmm_rise |-> ##2 !irq_n)
        else $error("mismatch did not lower the interrupt");
endmodule

bind leism_top leism_checker i_leism_checker (.*);

// >>> test/tb_top.sv
// Self-checking bench for the link error summary and interrupt block.
`timescale 1ns/100ps
`include "leism_defs.vh"

module tb_top;
    // ====================
    // Signals
    logic        aclk, aresetn, config_mismatch, link_sync_output_n, irq_n;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  lane_disparity_err, lane_not_in_table_err;
    logic [7:0]  lane_unexpected_ctrl_err, lane_code_group_fail;
    logic [7:0]  lane_frame_align_fail, lane_checksum_err;
    logic [7:0]  lane_alignment_fail;
    int          num_errors, samples_checked, cycles, sync_reqs;
    localparam logic [1:0] rsp_ok = `LEISM_RESP_OKAY;

    leism_top i_leism_top (.*);
    leism_sync_rx i_leism_sync_rx (.aclk, .aresetn, .link_sync_output_n,
                                   .req_count(sync_reqs));

    // ====================
    // Shared tasks
    task automatic stop_test;
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // Bready or rready stands from the start; each valid drops when taken.
    task automatic axi(input bit wr, input [11:0] idx, input [7:0] d,
                       input [7:0] ed, input [1:0] er);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr} <= {idx, 2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (!wr)
            check(s_axi_rdata, {24'h0, ed});
        check({30'h0, wr ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
    endtask

    task automatic pulse(input int k);
        @(posedge aclk);
        {lane_disparity_err, lane_not_in_table_err,
         lane_unexpected_ctrl_err} <= 24'h000004 << (8 * (k - 5));
        @(posedge aclk);
        {lane_disparity_err, lane_not_in_table_err,
         lane_unexpected_ctrl_err} <= 24'h000000;
    endtask

    // ====================
    // Scenarios
    task automatic test_fail_summary;
        @(posedge aclk);
        lane_code_group_fail <= 8'h11;
        lane_frame_align_fail <= 8'h02;
        lane_checksum_err <= 8'h08;
        lane_alignment_fail <= 8'h40;
        wait_clk(2);
        axi(0, `LEISM_IDX_ERR_FLAGS, 0, 8'h07, rsp_ok);
        axi(0, `LEISM_IDX_CSUM_LANES, 0, 8'h08, rsp_ok);
        @(posedge aclk);
        lane_alignment_fail <= 8'h01;
        wait_clk(2);
        axi(0, `LEISM_IDX_ERR_FLAGS, 0, 8'h0F, rsp_ok);
        @(posedge aclk);
        {lane_code_group_fail, lane_frame_align_fail} <= 16'h0;
        {lane_checksum_err, lane_alignment_fail} <= 16'h0;
    endtask

    // Threshold of three: two errors must not trip, the third must.
    task automatic test_error_sync;
        int k, n;
        axi(1, `LEISM_IDX_THRESHOLD, 8'h03, 0, rsp_ok);
        for (k = 7; k >= 5; k--) begin
            axi(1, `LEISM_IDX_SYNC_MASK, 8'h01 << k, 0, rsp_ok);
            axi(1, `LEISM_IDX_ERR_FLAGS, 8'h01 << k, 0, rsp_ok);
            n = sync_reqs;
            pulse(k);
            pulse(k);
            wait_clk(3);
            check(link_sync_output_n, 1'b1);
            pulse(k);
            wait_clk(3);
            check(link_sync_output_n, 1'b0);
            check(irq_n, 1'b0);
            check(sync_reqs, n + 1);
            axi(0, `LEISM_IDX_ERR_FLAGS, 0, 8'h01 << k, rsp_ok);
            axi(0, 12'h46D + 12'(7 - k), 0, 8'h04, rsp_ok);
            axi(1, `LEISM_IDX_CNT_CLEAR, 8'h01 << (7 - k), 0, rsp_ok);
            axi(1, `LEISM_IDX_IRQ_STATUS, 8'h01 << k, 0, rsp_ok);
            wait_clk(3);
            check(link_sync_output_n, 1'b1);
            check(irq_n, 1'b1);
        end
    endtask

    task automatic test_mismatch;
        axi(1, `LEISM_IDX_SYNC_MASK, 8'h00, 0, rsp_ok);
        @(posedge aclk);
        config_mismatch <= 1'b1;
        wait_clk(3);
        check(irq_n, 1'b1);
        axi(0, `LEISM_IDX_SYNC_MASK, 0, 8'h00, rsp_ok);
        @(posedge aclk);
        config_mismatch <= 1'b0;
        axi(1, `LEISM_IDX_SYNC_MASK, 8'h08, 0, rsp_ok);
        @(posedge aclk);
        config_mismatch <= 1'b1;
        wait_clk(3);
        check(irq_n, 1'b0);
        axi(0, `LEISM_IDX_SYNC_MASK, 0, 8'h18, rsp_ok);
        axi(0, `LEISM_IDX_ERR_FLAGS, 0, 8'h00, rsp_ok);
        axi(0, `LEISM_IDX_IRQ_MASK, 0, 8'h20, rsp_ok);
        axi(1, `LEISM_IDX_SYNC_MASK, 8'h18, 0, rsp_ok);
        wait_clk(2);
        check(irq_n, 1'b1);
        axi(0, `LEISM_IDX_SYNC_MASK, 0, 8'h08, rsp_ok);
        @(posedge aclk);
        config_mismatch <= 1'b0;
    endtask

    // ====================
    // Clock, watchdog and main sequence
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test;
        end
    end

    initial begin
        aresetn = 1'b0;
        s_axi_wstrb = 4'hF;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, config_mismatch} = 6'h00;
        {lane_disparity_err, lane_not_in_table_err, lane_unexpected_ctrl_err,
         lane_code_group_fail, lane_frame_align_fail, lane_checksum_err,
         lane_alignment_fail} = 56'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi(0, `LEISM_IDX_THRESHOLD, 0, 8'hFF, rsp_ok);
        axi(0, `LEISM_IDX_SYNC_MASK, 0, 8'h00, rsp_ok);
        test_fail_summary;
        test_error_sync;
        test_mismatch;
        axi(1, 12'h479, 8'hFF, 0, `LEISM_RESP_SLVERR);
        axi(0, 12'h479, 0, 8'h00, `LEISM_RESP_SLVERR);
        stop_test;
    end
endmodule
